/* bpm_pkg.sv */
// package: boot mode and program map constants and types
package bpm_pkg;

	localparam int PADDR_W = 21;

	localparam logic [20:0] BOOT_VEC_HI   = 21'h04_0000;
	localparam logic [20:0] WDOG_VEC_HI   = 21'h04_0002;
	localparam logic [20:0] BOOT_VEC_LO   = 21'h00_0000;
	localparam logic [20:0] WDOG_VEC_LO   = 21'h00_0002;

	localparam logic [20:0] REG_EXT_TOP   = 21'h10_0000;
	localparam logic [20:0] REG_EXT20_BEG = 21'h05_0000;
	localparam logic [20:0] REG_PRAM_BEG  = 21'h04_F800;
	localparam logic [20:0] REG_RSV_BEG   = 21'h04_4000;
	localparam logic [20:0] REG_BOOT_BEG  = 21'h04_0000;
	localparam logic [20:0] REG_PF1_BEG   = 21'h02_0000;
	localparam logic [20:0] REG_PF_BEG    = 21'h01_0000;

	localparam logic [20:0] REACH_16      = 21'h00_FFFF;
	localparam logic [20:0] REACH_20      = 21'h0F_FFFF;

	localparam logic [4:0] ADDR_LINES_16  = 5'h10;
	localparam logic [4:0] ADDR_LINES_20  = 5'h14;

	localparam logic SEC_LOCKED   = 1'h0;
	localparam logic SEC_UNLOCKED = 1'h1;

	typedef enum logic [2:0] {
		BPM_TGT_FLASH,
		BPM_TGT_BOOT,
		BPM_TGT_PRAM,
		BPM_TGT_RSVD,
		BPM_TGT_EXT
	} bpm_tgt_t;

	typedef struct packed {
		logic                valid;
		logic                write;
		logic [PADDR_W-1:0]  addr;
	} bpm_req_t;

	typedef struct packed {
		logic       flash;
		logic       boot;
		logic       pram;
		logic       rsvd;
		logic       ext;
		logic       blocked;
		logic       flash_blk;
	} bpm_sel_t;

	typedef struct packed {
		logic       program_req;
		logic       erase_req;
		logic       data_flash;
		logic       rd_secondary;
		logic       rd_valid;
	} bpm_fiu_t;

endpackage : bpm_pkg

/* bpm_boot_map.sv */
// boot mode latch and program space decoder
`timescale 1ns/1ps

module bpm_boot_map (
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              flash_secured,
	input  wire logic              external_boot_select_pin,
	input  wire logic              address_width_pin,
	input  wire logic              omr_wr_boot_source,
	input  wire logic              omr_wr_security,
	input  wire logic              omr_wr_data,
	input  bpm_pkg::bpm_req_t      preq,
	input  bpm_pkg::bpm_fiu_t      fiu_req,
	input  wire logic              fiu_block_sel,
	output logic                   boot_source_bit,
	output logic                   security_latch_bit,
	output logic                   ext_boot,
	output logic [4:0]             addr_lines,
	output logic                   hi_addr_en,
	output logic                   debug_en,
	output logic                   chip_select_zero_is_ps,
	output logic                   chip_select_one_is_ds,
	output logic [20:0]            reset_vector,
	output logic [20:0]            wdog_vector,
	output bpm_pkg::bpm_sel_t      psel,
	output logic                   fiu_prog_blk0,
	output logic                   fiu_prog_blk1,
	output logic                   fiu_erase_blk0,
	output logic                   fiu_erase_blk1,
	output logic                   df_rd_core,
	output logic                   df_rd_secondary,
	output logic                   map_ready
);
	import bpm_pkg::*;

	typedef enum logic [1:0] {
		BPM_ST_RESET,
		BPM_ST_LATCH,
		BPM_ST_RUN
	} bpm_state_t;

	typedef struct packed {
		bpm_state_t  st;
		logic        sec;
		logic        sec_sw;
		logic        src;
		logic        src_rst;
		logic        wide;
		logic        ext_boot;
		logic [4:0]  lines;
		logic        hi_en;
		logic        dbg;
		logic        cs0_ps;
		logic        cs1_ds;
		logic [20:0] rvec;
		logic [20:0] wvec;
		bpm_sel_t    sel;
		logic        pb0;
		logic        pb1;
		logic        eb0;
		logic        eb1;
		logic        dfc;
		logic        dfs;
		logic        ready;
	} bpm_regs_t;

	bpm_regs_t r_q;
	bpm_regs_t r_d;

	// one-hot decode of an address under the current map
	function automatic bpm_sel_t decode(input logic [20:0] a, input logic ext_map,
	                                    input logic wide, input logic sec);
		bpm_sel_t s;
		logic [20:0] reach;
		s = '0;
		reach = wide ? REACH_20 : REACH_16;
		// 050000 and up is external in every map, reach and security decide blocking
		if (a >= REG_EXT20_BEG) begin
			s.ext = 1'b1;
		end else if (a >= REG_PRAM_BEG) begin
			s.pram = 1'b1;
		end else if (a >= REG_RSV_BEG) begin
			s.rsvd = 1'b1;
		end else if (a >= REG_BOOT_BEG) begin
			if (ext_map && wide)
				s.ext = 1'b1;
			else
				s.boot = 1'b1;
		end else if (a < REG_PF_BEG && ext_map && !wide) begin
			s.ext = 1'b1;
		end else begin
			s.flash = 1'b1;
		end
		s.flash_blk = (a >= REG_PF1_BEG);
		// external targets beyond reset reach, or any external when secured
		if (s.ext && (a > reach || !sec))
			s.blocked = 1'b1;
		return s;
	endfunction : decode

	always_comb begin
		r_d = r_q;
		r_d.pb0 = 1'b0;
		r_d.pb1 = 1'b0;
		r_d.eb0 = 1'b0;
		r_d.eb1 = 1'b0;
		r_d.dfc = 1'b0;
		r_d.dfs = 1'b0;
		unique case (r_q.st)
			BPM_ST_RESET: begin
				r_d.st = BPM_ST_LATCH;
			end
			BPM_ST_LATCH: begin
				r_d.sec = flash_secured ? SEC_LOCKED : SEC_UNLOCKED;
				r_d.sec_sw = r_d.sec;
				r_d.src = external_boot_select_pin & ~flash_secured;
				r_d.src_rst = r_d.src;
				r_d.wide = address_width_pin;
				r_d.ext_boot = r_d.src;
				r_d.lines = (r_d.src && address_width_pin) ? ADDR_LINES_20 : ADDR_LINES_16;
				// upper four lines only when wide
				r_d.hi_en = r_d.src && address_width_pin;
				r_d.dbg = ~flash_secured;
				r_d.cs0_ps = 1'b1;
				r_d.cs1_ds = 1'b1;
				if (r_d.src && !address_width_pin) begin
					r_d.rvec = BOOT_VEC_LO;
					r_d.wvec = WDOG_VEC_LO;
				end else begin
					r_d.rvec = BOOT_VEC_HI;
					r_d.wvec = WDOG_VEC_HI;
				end
				r_d.ready = 1'b1;
				r_d.st = BPM_ST_RUN;
			end
			BPM_ST_RUN: begin
				// switch only if unsecured at reset
				if (omr_wr_boot_source && r_q.sec == SEC_UNLOCKED)
					r_d.src = omr_wr_data;
				if (omr_wr_security)
					r_d.sec_sw = omr_wr_data;
				if (preq.valid)
					r_d.sel = decode(preq.addr, r_q.src, r_q.hi_en, r_q.sec);
				else
					r_d.sel = '0;
				// flash ops through unit only, per block
				r_d.pb0 = fiu_req.program_req && !fiu_req.data_flash && !fiu_block_sel;
				r_d.pb1 = fiu_req.program_req && !fiu_req.data_flash && fiu_block_sel;
				r_d.eb0 = fiu_req.erase_req && !fiu_req.data_flash && !fiu_block_sel;
				r_d.eb1 = fiu_req.erase_req && !fiu_req.data_flash && fiu_block_sel;
				r_d.dfc = fiu_req.rd_valid && fiu_req.data_flash && !fiu_req.rd_secondary;
				r_d.dfs = fiu_req.rd_valid && fiu_req.data_flash && fiu_req.rd_secondary;
			end
			default: r_d.st = BPM_ST_RESET;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r_q <= '0;
			r_q.st <= BPM_ST_RESET;
			r_q.lines <= ADDR_LINES_16;
			r_q.cs0_ps <= 1'b1;
			r_q.cs1_ds <= 1'b1;
			r_q.rvec <= BOOT_VEC_HI;
			r_q.wvec <= WDOG_VEC_HI;
		end else begin
			r_q <= r_d;
		end
	end

	assign boot_source_bit        = r_q.src;
	assign security_latch_bit     = r_q.sec_sw;
	assign ext_boot               = r_q.ext_boot;
	assign addr_lines             = r_q.lines;
	assign hi_addr_en             = r_q.hi_en;
	assign debug_en               = r_q.dbg;
	assign chip_select_zero_is_ps = r_q.cs0_ps;
	assign chip_select_one_is_ds  = r_q.cs1_ds;
	assign reset_vector           = r_q.rvec;
	assign wdog_vector            = r_q.wvec;
	assign psel                   = r_q.sel;
	assign fiu_prog_blk0          = r_q.pb0;
	assign fiu_prog_blk1          = r_q.pb1;
	assign fiu_erase_blk0         = r_q.eb0;
	assign fiu_erase_blk1         = r_q.eb1;
	assign df_rd_core             = r_q.dfc;
	assign df_rd_secondary        = r_q.dfs;
	assign map_ready              = r_q.ready;

	property p_one_target;
		@(posedge clock) disable iff (!nrst)
		$past(preq.valid) && r_q.st == BPM_ST_RUN && $past(r_q.st) == BPM_ST_RUN
		|-> $onehot({r_q.sel.flash, r_q.sel.boot, r_q.sel.pram, r_q.sel.rsvd, r_q.sel.ext});
	endproperty
	a_one_target: assert property (p_one_target)
		else $error("target select not one-hot");

	property p_secured_forces_zero;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_LATCH && flash_secured |=> !r_q.src && !r_q.ext_boot && !r_q.dbg;
	endproperty
	a_secured_forces_zero: assert property (p_secured_forces_zero)
		else $error("secured boot not mode 0");

	property p_sec_latch;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_LATCH |=> r_q.sec == !$past(flash_secured);
	endproperty
	a_sec_latch: assert property (p_sec_latch)
		else $error("security bit not latched");

	property p_src_latch;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_LATCH && !flash_secured |=> r_q.src == $past(external_boot_select_pin);
	endproperty
	a_src_latch: assert property (p_src_latch)
		else $error("boot source not latched");

	property p_sec_stable;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN |=> $stable(r_q.sec);
	endproperty
	a_sec_stable: assert property (p_sec_stable)
		else $error("security latch changed in run");

	property p_locked_src;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN && r_q.sec == SEC_LOCKED |=> !r_q.src;
	endproperty
	a_locked_src: assert property (p_locked_src)
		else $error("boot source changed while secured");

	property p_lines;
		@(posedge clock) disable iff (!nrst)
		r_q.ready |-> r_q.lines == ((r_q.ext_boot && r_q.wide) ? ADDR_LINES_20 : ADDR_LINES_16);
	endproperty
	a_lines: assert property (p_lines)
		else $error("address line count wrong");

	property p_vectors;
		@(posedge clock) disable iff (!nrst)
		r_q.ready && r_q.ext_boot && !r_q.wide |-> r_q.rvec == BOOT_VEC_LO && r_q.wvec == WDOG_VEC_LO;
	endproperty
	a_vectors: assert property (p_vectors)
		else $error("low vectors wrong");

	property p_vectors_hi;
		@(posedge clock) disable iff (!nrst)
		r_q.ready && !(r_q.ext_boot && !r_q.wide)
		|-> r_q.rvec == BOOT_VEC_HI && r_q.wvec == WDOG_VEC_HI;
	endproperty
	a_vectors_hi: assert property (p_vectors_hi)
		else $error("high vectors wrong");

	property p_df_one_bus;
		@(posedge clock) disable iff (!nrst)
		!(r_q.dfc && r_q.dfs);
	endproperty
	a_df_one_bus: assert property (p_df_one_bus)
		else $error("data flash on both buses");

	property p_blk_separate;
		@(posedge clock) disable iff (!nrst)
		!(r_q.eb0 && r_q.eb1) && !(r_q.pb0 && r_q.pb1);
	endproperty
	a_blk_separate: assert property (p_blk_separate)
		else $error("both flash blocks hit");

	property p_debug_off;
		@(posedge clock) disable iff (!nrst)
		r_q.ready && r_q.sec == SEC_LOCKED
		|-> !r_q.dbg && !r_q.ext_boot && r_q.lines == ADDR_LINES_16;
	endproperty
	a_debug_off: assert property (p_debug_off)
		else $error("secured mode not fully internal");

	property p_hi_lines;
		@(posedge clock) disable iff (!nrst)
		r_q.ready |-> r_q.hi_en == (r_q.ext_boot && r_q.wide);
	endproperty
	a_hi_lines: assert property (p_hi_lines)
		else $error("upper address lines enable wrong");

	property p_sec_write;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN && omr_wr_security && !omr_wr_boot_source
		|=> $stable(r_q.sec) && $stable(r_q.src);
	endproperty
	a_sec_write: assert property (p_sec_write)
		else $error("security write moved map or latch");

	property p_boot_region_ext;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN && preq.valid && r_q.src && r_q.hi_en
		&& preq.addr >= REG_BOOT_BEG && preq.addr < REG_RSV_BEG |=> r_q.sel.ext;
	endproperty
	a_boot_region_ext: assert property (p_boot_region_ext)
		else $error("boot region not external in wide map");

	property p_reach;
		@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN && preq.valid
		&& (preq.addr >= REG_EXT_TOP || (preq.addr >= REG_EXT20_BEG && !r_q.hi_en))
		|=> r_q.sel.ext && r_q.sel.blocked;
	endproperty
	a_reach: assert property (p_reach)
		else $error("address beyond reach not blocked");

	property p_flash_unit;
		@(posedge clock) disable iff (!nrst)
		!fiu_req.program_req && !fiu_req.erase_req
		|=> !r_q.pb0 && !r_q.pb1 && !r_q.eb0 && !r_q.eb1;
	endproperty
	a_flash_unit: assert property (p_flash_unit)
		else $error("flash operation without unit request");

	c_ext_boot_wide: cover property (@(posedge clock) disable iff (!nrst)
		r_q.ready && r_q.ext_boot && r_q.wide);
	c_ext_boot_narrow: cover property (@(posedge clock) disable iff (!nrst)
		r_q.ready && r_q.ext_boot && !r_q.wide);
	c_secured: cover property (@(posedge clock) disable iff (!nrst)
		r_q.ready && r_q.sec == SEC_LOCKED);
	c_blocked: cover property (@(posedge clock) disable iff (!nrst)
		r_q.sel.blocked);
	c_src_switch: cover property (@(posedge clock) disable iff (!nrst)
		r_q.st == BPM_ST_RUN && omr_wr_boot_source && r_q.sec == SEC_UNLOCKED);

endmodule : bpm_boot_map

/* bpm_core_model.sv */
// core model issuing program space fetches
`timescale 1ns/1ps
module bpm_core_model
	import bpm_pkg::*;
(
	input  wire logic        clock,
	output bpm_pkg::bpm_req_t preq,
	input  bpm_pkg::bpm_sel_t psel
);
	initial preq = '0;
	// request held over the taking edge; released address inverted, not left stale
	task automatic fetch(input logic [20:0] addr, output logic [6:0] sel);
		@(negedge clock);
		preq = '{valid: 1'b1, write: 1'b0, addr: addr};
		@(negedge clock);
		sel = psel;
		preq = '{valid: 1'b0, write: 1'b0, addr: ~addr};
	endtask : fetch
endmodule : bpm_core_model

/* test_bpm_boot_map.sv */
// self-checking bench for boot mode latch and program map
`timescale 1ns/1ps
module test_bpm_boot_map;
	import bpm_pkg::*;
	logic clock = 0, nrst = 0, flash_secured = 0, external_boot_select_pin = 0;
	logic address_width_pin = 0, omr_wr_boot_source = 0, omr_wr_security = 0;
	logic omr_wr_data = 0, fiu_block_sel = 0;
	bpm_req_t preq;
	bpm_fiu_t fiu_req = '0;
	bpm_sel_t psel;
	logic boot_source_bit, security_latch_bit, ext_boot, hi_addr_en, debug_en, map_ready;
	logic chip_select_zero_is_ps, chip_select_one_is_ds, df_rd_core, df_rd_secondary;
	logic fiu_prog_blk0, fiu_prog_blk1, fiu_erase_blk0, fiu_erase_blk1;
	logic [4:0] addr_lines;
	logic [20:0] reset_vector, wdog_vector;
	logic [6:0] got;
	int fail_count = 0, checked = 0;
	localparam logic [20:0] PROBE [8] = '{21'h00_FFFF, 21'h01_0000, 21'h03_FFFF, 21'h04_0000,
		21'h04_3FFF, 21'h04_4000, 21'h04_F7FF, 21'h04_F800};
	localparam logic [2:0] MODES [5] = '{3'b100, 3'b111, 3'b000, 3'b010, 3'b011};

	bpm_boot_map DUT (.clock, .nrst, .flash_secured, .external_boot_select_pin,
		.address_width_pin, .omr_wr_boot_source, .omr_wr_security, .omr_wr_data, .preq,
		.fiu_req, .fiu_block_sel, .boot_source_bit, .security_latch_bit, .ext_boot,
		.addr_lines, .hi_addr_en, .debug_en, .chip_select_zero_is_ps, .chip_select_one_is_ds,
		.reset_vector, .wdog_vector, .psel, .fiu_prog_blk0, .fiu_prog_blk1, .fiu_erase_blk0,
		.fiu_erase_blk1, .df_rd_core, .df_rd_secondary, .map_ready);
	bpm_core_model core (.clock, .preq, .psel);

	always #10 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	// straps held across reset and the sampling edge after release
	task automatic boot(input logic sec, input logic pin, input logic wid);
		logic ext, wide;
		ext = pin & ~sec;
		wide = ext & wid;
		@(negedge clock);
		nrst = 0;
		flash_secured = sec;
		external_boot_select_pin = pin;
		address_width_pin = wid;
		repeat (4) @(negedge clock);
		nrst = 1;
		for (int n = 0; n < 8 && map_ready !== 1'b1; n++) @(negedge clock);
		check(map_ready, 1);
		check(security_latch_bit, !sec);
		check(boot_source_bit, ext);
		check(ext_boot, ext);
		check(addr_lines, wide ? ADDR_LINES_20 : ADDR_LINES_16);
		check(hi_addr_en, wide);
		check(debug_en, !sec);
		check({chip_select_zero_is_ps, chip_select_one_is_ds}, 2'b11);
		check(reset_vector, (ext && !wide) ? BOOT_VEC_LO : BOOT_VEC_HI);
		check(wdog_vector, (ext && !wide) ? WDOG_VEC_LO : WDOG_VEC_HI);
	endtask : boot

	// expected one-hot target per probe address, blocked bit low
	task automatic map(input logic ext, input logic wide);
		logic [4:0] e;
		for (int i = 0; i < 8; i++) begin
			if (PROBE[i] < REG_PF_BEG) e = (ext && !wide) ? 5'h01 : 5'h10;
			else if (PROBE[i] < REG_BOOT_BEG) e = 5'h10;
			else if (PROBE[i] < REG_RSV_BEG) e = wide ? 5'h01 : 5'h08;
			else if (PROBE[i] < REG_PRAM_BEG) e = 5'h02;
			else e = 5'h04;
			core.fetch(PROBE[i], got);
			check(got, {e, 1'b0, PROBE[i] >= REG_PF1_BEG});
		end
	endtask : map

	task automatic wr(input logic boot_src, input logic d);
		@(negedge clock);
		omr_wr_boot_source = boot_src;
		omr_wr_security = !boot_src;
		omr_wr_data = d;
		@(negedge clock);
		omr_wr_boot_source = 0;
		omr_wr_security = 0;
	endtask : wr

	task automatic fiu(input bpm_fiu_t f, input logic blk, input logic [5:0] exp);
		@(negedge clock);
		fiu_req = f;
		fiu_block_sel = blk;
		@(negedge clock);
		fiu_req = '0;
		check({fiu_prog_blk0, fiu_prog_blk1, fiu_erase_blk0, fiu_erase_blk1,
			df_rd_core, df_rd_secondary}, exp);
	endtask : fiu

	initial begin
		#100000;
		fail_count++;
		close_out();
	end

	initial begin
		for (int k = 0; k < 5; k++) begin
			boot(MODES[k][2], MODES[k][1], MODES[k][0]);
			map(MODES[k][1] & ~MODES[k][2], &MODES[k][1:0] & ~MODES[k][2]);
			$display("mode test %0d done", k);
		end
		core.fetch(REG_EXT20_BEG, got);
		check(got[6:1], 6'h02);
		core.fetch(REG_EXT_TOP, got);
		check(got[1], 1);
		boot(0, 1, 0);
		core.fetch(REG_EXT_TOP, got);
		check(got[1], 1);
		core.fetch(REG_EXT20_BEG, got);
		check(got[6:1], 6'h03);
		$display("reach test done");
		boot(0, 0, 0);
		wr(1, 1);
		check(boot_source_bit, 1);
		map(1, 0);
		flash_secured = 1;
		repeat (3) @(negedge clock);
		check(security_latch_bit, 1);
		wr(0, 0);
		check(security_latch_bit, 0);
		map(1, 0);
		boot(1, 0, 0);
		wr(1, 1);
		check(boot_source_bit, 0);
		map(0, 0);
		$display("mode write test done");
		fiu('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 0, 6'b100000);
		fiu('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 1, 6'b000100);
		fiu('{1'b0, 1'b0, 1'b1, 1'b0, 1'b1}, 0, 6'b000010);
		fiu('{1'b0, 1'b0, 1'b1, 1'b1, 1'b1}, 0, 6'b000001);
		$display("flash unit test done");
		close_out();
	end
endmodule : test_bpm_boot_map
